// ==== mvcu_pkg.sv ====
// Purpose: Constants and types for the move and conditional move unit
// Assumes: Operand kinds and condition codes arrive already decoded
// Notes: Condition codes follow the usual sixteen-entry order, each pair on one code
// Function
// - Plain transfer loads memory into general or segment register, and stores both.
// - Register transfers: general to general; general to and from segment, control, debug.
// - Immediate source may go to a general register or to memory.
// - No memory to memory or segment to segment path; string copy does that.
// - Conditional transfer moves 16 or 32 bits, memory or general into general.
// - False condition: no move, continue with next instruction.
// - Above is true when carry OR zero equals 0.
// - Below or equal is true when carry OR zero equals 1.
// - Above or equal and no carry share one code, true when carry is 0.
// - Below and carry are true when carry is 1.
// - Zero, parity, overflow and sign codes test their single flag set or clear.
// - Greater or equal when sign XOR overflow is 0; less when it is 1.
// - Less or equal when (sign XOR overflow) OR zero equals 1.
// - Paired condition names decode to one identical encoding and behaviour.
// - Feature query reports whether conditional transfers are implemented.
package mvcu_pkg;
	localparam int MVCU_DATA_W = 32;
	localparam int MVCU_REG_IDX_W = 3;
	localparam int MVCU_W16 = 16;

	// Operand location kinds
	typedef enum logic [2:0] {
		MVCU_LOC_MEM = 3'b000,
		MVCU_LOC_GPR = 3'b001,
		MVCU_LOC_SEG = 3'b010,
		MVCU_LOC_CTL = 3'b011,
		MVCU_LOC_DBG = 3'b100,
		MVCU_LOC_IMM = 3'b101
	} mvcu_loc_e;

	// Condition encodings; alternate names share a code
	typedef enum logic [3:0] {
		MVCU_CC_O = 4'h0,
		MVCU_CC_NO = 4'h1,
		MVCU_CC_B = 4'h2,
		MVCU_CC_AE = 4'h3,
		MVCU_CC_E = 4'h4,
		MVCU_CC_NE = 4'h5,
		MVCU_CC_BE = 4'h6,
		MVCU_CC_A = 4'h7,
		MVCU_CC_S = 4'h8,
		MVCU_CC_NS = 4'h9,
		MVCU_CC_P = 4'hA,
		MVCU_CC_NP = 4'hB,
		MVCU_CC_L = 4'hC,
		MVCU_CC_GE = 4'hD,
		MVCU_CC_LE = 4'hE,
		MVCU_CC_G = 4'hF
	} mvcu_cc_e;

	// Arithmetic status flags subset
	typedef struct packed {
		logic overflow_flag;
		logic sign_flag;
		logic zero_flag;
		logic parity_flag;
		logic carry_flag;
	} mvcu_flags_s;

	// One decoded transfer request
	typedef struct packed {
		logic valid;
		logic is_cond;
		logic size32;
		mvcu_cc_e cc;
		mvcu_loc_e src;
		mvcu_loc_e dst;
		logic [MVCU_REG_IDX_W-1:0] dst_idx;
		logic [MVCU_DATA_W-1:0] src_data;
		logic [MVCU_DATA_W-1:0] dst_old;
	} mvcu_req_s;

	// Result towards register file and memory path
	typedef struct packed {
		logic done;
		logic illegal;
		logic write_en;
		logic cond_true;
		mvcu_loc_e dst;
		logic [MVCU_REG_IDX_W-1:0] dst_idx;
		logic [MVCU_DATA_W-1:0] data;
	} mvcu_res_s;

	localparam logic [MVCU_DATA_W-1:0] MVCU_ZERO = 32'h0000_0000;
	localparam logic MVCU_HAS_CMOV_DEF = 1'b1;
endpackage : mvcu_pkg

// ==== mvcu_top.sv ====
// Purpose: Path check and condition evaluation for plain and conditional transfers
// Assumes: One request per cycle, result one cycle later; flags valid with request
// Notes: Flags are only read, never written by this block
`timescale 1ns/1ps
module mvcu_top import mvcu_pkg::*; #(
	parameter logic HAS_CMOV = MVCU_HAS_CMOV_DEF
) (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire mvcu_req_s i_req,
	input wire mvcu_flags_s i_flags,
	output mvcu_res_s o_res,
	output logic o_cmov_supported
);

	// Condition evaluation, shared by logic and checks; one code per name pair
	function automatic logic cc_eval(input mvcu_cc_e cc, input mvcu_flags_s f);
		logic r;
		r = 1'b0;
		unique case (cc)
			MVCU_CC_O: r = f.overflow_flag;
			MVCU_CC_NO: r = !f.overflow_flag;
			MVCU_CC_B: r = f.carry_flag;
			MVCU_CC_AE: r = !f.carry_flag;
			MVCU_CC_E: r = f.zero_flag;
			MVCU_CC_NE: r = !f.zero_flag;
			MVCU_CC_BE: r = f.carry_flag | f.zero_flag;
			MVCU_CC_A: r = !(f.carry_flag | f.zero_flag);
			MVCU_CC_S: r = f.sign_flag;
			MVCU_CC_NS: r = !f.sign_flag;
			MVCU_CC_P: r = f.parity_flag;
			MVCU_CC_NP: r = !f.parity_flag;
			MVCU_CC_L: r = f.sign_flag ^ f.overflow_flag;
			MVCU_CC_GE: r = !(f.sign_flag ^ f.overflow_flag);
			MVCU_CC_LE: r = (f.sign_flag ^ f.overflow_flag) | f.zero_flag;
			MVCU_CC_G: r = !((f.sign_flag ^ f.overflow_flag) | f.zero_flag);
		endcase
		return r;
	endfunction : cc_eval

	// Legal plain transfer paths; anything not listed is refused
	function automatic logic plain_ok(input mvcu_loc_e s, input mvcu_loc_e d);
		logic ok;
		ok = 1'b0;
		unique case (d)
			MVCU_LOC_GPR: begin
				// Every source kind may land in a general register
				ok = (s == MVCU_LOC_MEM) || (s == MVCU_LOC_GPR) || (s == MVCU_LOC_SEG)
					|| (s == MVCU_LOC_CTL) || (s == MVCU_LOC_DBG)
					|| (s == MVCU_LOC_IMM);
			end
			MVCU_LOC_MEM: begin
				// No memory source: memory copies belong to the string copy path
				ok = (s == MVCU_LOC_GPR) || (s == MVCU_LOC_SEG)
					|| (s == MVCU_LOC_IMM);
			end
			MVCU_LOC_SEG: begin
				// No segment source and no immediate into a segment register
				ok = (s == MVCU_LOC_MEM) || (s == MVCU_LOC_GPR);
			end
			MVCU_LOC_CTL, MVCU_LOC_DBG: begin
				ok = (s == MVCU_LOC_GPR);
			end
			MVCU_LOC_IMM: begin
				ok = 1'b0; // An immediate is never a destination
			end
			default: begin
				ok = 1'b0; // Codes beyond the enum are refused
			end
		endcase
		return ok;
	endfunction : plain_ok

	logic cond_now;
	logic legal_now;
	logic [MVCU_DATA_W-1:0] src_sized;
	logic [MVCU_DATA_W-1:0] merged;

	// Decode of the current request
	always_comb begin
		cond_now = cc_eval(i_req.cc, i_flags);
		if (i_req.is_cond) begin
			legal_now = HAS_CMOV && (i_req.dst == MVCU_LOC_GPR)
				&& ((i_req.src == MVCU_LOC_GPR) || (i_req.src == MVCU_LOC_MEM));
		end else begin
			legal_now = plain_ok(i_req.src, i_req.dst);
		end
		// A 16-bit move leaves the upper half of the destination alone
		src_sized = i_req.size32 ? i_req.src_data
			: {i_req.dst_old[MVCU_DATA_W-1:MVCU_W16], i_req.src_data[MVCU_W16-1:0]};
		merged = (i_req.is_cond && !cond_now) ? i_req.dst_old : src_sized;
	end

	// Result register
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			o_res <= '{done: 1'b0, illegal: 1'b0, write_en: 1'b0, cond_true: 1'b0,
				dst: MVCU_LOC_MEM, dst_idx: '0, data: MVCU_ZERO};
		end else begin
			o_res.done <= i_req.valid;
			o_res.illegal <= i_req.valid && !legal_now;
			// False condition drops the write; next instruction follows
			o_res.write_en <= i_req.valid && legal_now && (!i_req.is_cond || cond_now);
			o_res.cond_true <= i_req.valid && i_req.is_cond && cond_now;
			o_res.dst <= i_req.dst;
			o_res.dst_idx <= i_req.dst_idx;
			o_res.data <= merged;
		end
	end

	// Feature report, fixed at build
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			o_cmov_supported <= 1'b0;
		end else begin
			o_cmov_supported <= HAS_CMOV;
		end
	end

	// False condition request, a case that must never write
	sequence s_cond_false_req;
		i_req.valid && i_req.is_cond && !cc_eval(i_req.cc, i_flags);
	endsequence

	// Request shapes shared by the path, condition and destination checks
	sequence s_plain_req;
		i_req.valid && !i_req.is_cond;
	endsequence

	sequence s_cond_req;
		i_req.valid && i_req.is_cond;
	endsequence

	// Condition decode, checked against the flags one edge back
	a_cond_false_nowrite: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_false_req |=> o_res.done && !o_res.write_en)
		else $error("false condition wrote");
	a_above_flags: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && i_req.is_cond && i_req.cc == MVCU_CC_A && HAS_CMOV
		&& i_req.src == MVCU_LOC_GPR && i_req.dst == MVCU_LOC_GPR
		|=> o_res.write_en == !($past(i_flags.carry_flag) | $past(i_flags.zero_flag)))
		else $error("above decode wrong");
	a_below_eq_flags: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && i_req.is_cond && i_req.cc == MVCU_CC_BE
		|=> o_res.cond_true == ($past(i_flags.carry_flag) | $past(i_flags.zero_flag)))
		else $error("below or equal decode wrong");
	a_carry_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && i_req.is_cond && i_req.cc == MVCU_CC_AE
		|=> o_res.cond_true == !$past(i_flags.carry_flag))
		else $error("carry clear decode wrong");
	a_carry_set: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && i_req.is_cond && i_req.cc == MVCU_CC_B
		|=> o_res.cond_true == $past(i_flags.carry_flag))
		else $error("carry set decode wrong");
	a_zero_single: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && i_req.is_cond && i_req.cc == MVCU_CC_E
		|=> o_res.cond_true == $past(i_flags.zero_flag))
		else $error("zero decode wrong");
	a_signed_less: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && i_req.is_cond && i_req.cc == MVCU_CC_L
		|=> o_res.cond_true == ($past(i_flags.sign_flag) ^ $past(i_flags.overflow_flag)))
		else $error("less decode wrong");
	a_signed_le: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && i_req.is_cond && i_req.cc == MVCU_CC_LE
		|=> o_res.cond_true == (($past(i_flags.sign_flag) ^ $past(i_flags.overflow_flag))
		| $past(i_flags.zero_flag)))
		else $error("less or equal decode wrong");
	a_parity_set: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_req ##0 (i_req.cc == MVCU_CC_P)
		|=> o_res.cond_true == $past(i_flags.parity_flag))
		else $error("parity decode wrong");
	a_overflow_set: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_req ##0 (i_req.cc == MVCU_CC_O)
		|=> o_res.cond_true == $past(i_flags.overflow_flag))
		else $error("overflow decode wrong");
	a_sign_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_req ##0 (i_req.cc == MVCU_CC_NS)
		|=> o_res.cond_true == !$past(i_flags.sign_flag))
		else $error("not sign decode wrong");
	a_signed_ge: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_req ##0 (i_req.cc == MVCU_CC_GE)
		|=> o_res.cond_true == !($past(i_flags.sign_flag) ^ $past(i_flags.overflow_flag)))
		else $error("greater or equal decode wrong");
	a_signed_gt: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_req ##0 (i_req.cc == MVCU_CC_G)
		|=> o_res.cond_true == !(($past(i_flags.sign_flag) ^ $past(i_flags.overflow_flag))
		| $past(i_flags.zero_flag)))
		else $error("greater decode wrong");

	// Plain transfer paths: listed ones write, the rest are refused
	a_mem_to_seg: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_plain_req ##0 (i_req.src == MVCU_LOC_MEM && i_req.dst == MVCU_LOC_SEG)
		|=> o_res.write_en && !o_res.illegal)
		else $error("memory to segment refused");
	a_gpr_to_ctl: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_plain_req ##0 (i_req.src == MVCU_LOC_GPR && i_req.dst == MVCU_LOC_CTL)
		|=> o_res.write_en && !o_res.illegal)
		else $error("general to control refused");
	a_dbg_to_gpr: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_plain_req ##0 (i_req.src == MVCU_LOC_DBG && i_req.dst == MVCU_LOC_GPR)
		|=> o_res.write_en && !o_res.illegal)
		else $error("debug to general refused");
	a_imm_to_mem: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_plain_req ##0 (i_req.src == MVCU_LOC_IMM && i_req.dst == MVCU_LOC_MEM
		&& i_req.size32)
		|=> o_res.write_en && o_res.data == $past(i_req.src_data))
		else $error("immediate to memory wrong");
	a_no_mem_mem: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && !i_req.is_cond && i_req.src == MVCU_LOC_MEM && i_req.dst == MVCU_LOC_MEM
		|=> o_res.illegal && !o_res.write_en)
		else $error("memory to memory accepted");
	a_no_seg_seg: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_plain_req ##0 (i_req.src == MVCU_LOC_SEG && i_req.dst == MVCU_LOC_SEG)
		|=> o_res.illegal && !o_res.write_en)
		else $error("segment to segment accepted");

	// Width, destination and feature checks
	a_half_width: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_req.valid && !i_req.size32
		|=> o_res.data[MVCU_DATA_W-1:MVCU_W16] == $past(i_req.dst_old[MVCU_DATA_W-1:MVCU_W16]))
		else $error("upper half changed on short move");
	a_cond_dest_gpr: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_req ##0 (i_req.dst != MVCU_LOC_GPR)
		|=> o_res.illegal && !o_res.write_en)
		else $error("conditional move to non-general accepted");
	a_true_moves: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_req ##0 (HAS_CMOV && i_req.size32 && i_req.src == MVCU_LOC_MEM
		&& i_req.dst == MVCU_LOC_GPR && cc_eval(i_req.cc, i_flags))
		|=> o_res.write_en && o_res.data == $past(i_req.src_data))
		else $error("true condition did not move");
	a_keep_dest: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_cond_false_req |=> o_res.data == $past(i_req.dst_old))
		else $error("destination changed on false condition");
	a_feature_report: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		$past(I_RST_N) |-> o_cmov_supported == HAS_CMOV)
		else $error("feature report wrong");
endmodule : mvcu_top

// ==== mvcu_gpr_model.sv ====
// Purpose: General register file stand-in that supplies old destination values
// Assumes: A granted write lands on the edge after its result appears
// Notes: Only general registers are held; other targets are dropped
`timescale 1ns/1ps
module mvcu_gpr_model import mvcu_pkg::*; (
	input wire logic i_clk,
	input wire logic [MVCU_REG_IDX_W-1:0] i_idx,
	input wire mvcu_res_s i_res,
	output logic [MVCU_DATA_W-1:0] o_old
);
	logic [MVCU_DATA_W-1:0] gpr_r [8];
	// Known seed per register, so kept contents can be predicted
	initial for (int i = 0; i < 8; i++) gpr_r[i] = 32'h1111_1111 * i;
	// Commit only granted writes into general registers
	always @(posedge i_clk) begin
		if (i_res.write_en && i_res.dst == MVCU_LOC_GPR) begin
			gpr_r[i_res.dst_idx] <= i_res.data;
		end
	end
	assign o_old = gpr_r[i_idx];
endmodule : mvcu_gpr_model

// ==== move_and_conditional_move_unit_tb_top.sv ====
// Purpose: Self-checking bench for the move and conditional move unit
// Assumes: Inputs change on the falling edge; results are read one edge later
// Notes: Path table first, then condition sweep, partial width and reset
`timescale 1ns/1ps
module move_and_conditional_move_unit_tb_top import mvcu_pkg::*;;
	typedef struct packed {mvcu_loc_e s; mvcu_loc_e d; logic ill;} mvcu_row_s;
	logic I_CLK = 1'b0;
	logic I_RST_N = 1'b0;
	mvcu_req_s req_r = '0;
	mvcu_req_s req_w;
	mvcu_flags_s flags_r = '0;
	mvcu_res_s res_w;
	logic cmov_w;
	logic [MVCU_DATA_W-1:0] old_w;
	logic [MVCU_DATA_W-1:0] old_q;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	// Source, destination, refused
	mvcu_row_s rows [16] = '{
		'{MVCU_LOC_MEM, MVCU_LOC_GPR, 1'b0}, '{MVCU_LOC_MEM, MVCU_LOC_SEG, 1'b0},
		'{MVCU_LOC_GPR, MVCU_LOC_MEM, 1'b0}, '{MVCU_LOC_SEG, MVCU_LOC_MEM, 1'b0},
		'{MVCU_LOC_GPR, MVCU_LOC_GPR, 1'b0}, '{MVCU_LOC_GPR, MVCU_LOC_SEG, 1'b0},
		'{MVCU_LOC_SEG, MVCU_LOC_GPR, 1'b0}, '{MVCU_LOC_GPR, MVCU_LOC_CTL, 1'b0},
		'{MVCU_LOC_CTL, MVCU_LOC_GPR, 1'b0}, '{MVCU_LOC_GPR, MVCU_LOC_DBG, 1'b0},
		'{MVCU_LOC_DBG, MVCU_LOC_GPR, 1'b0}, '{MVCU_LOC_IMM, MVCU_LOC_GPR, 1'b0},
		'{MVCU_LOC_IMM, MVCU_LOC_MEM, 1'b0}, '{MVCU_LOC_MEM, MVCU_LOC_MEM, 1'b1},
		'{MVCU_LOC_SEG, MVCU_LOC_SEG, 1'b1}, '{MVCU_LOC_IMM, MVCU_LOC_SEG, 1'b1}};
	always #2 I_CLK = ~I_CLK;
	mvcu_top dut_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .i_req(req_w), .i_flags(flags_r),
		.o_res(res_w), .o_cmov_supported(cmov_w));
	mvcu_gpr_model gpr_u (.i_clk(I_CLK), .i_idx(req_r.dst_idx), .i_res(res_w), .o_old(old_w));
	// Destination contents come from the register file stand-in
	always_comb begin
		req_w = req_r;
		req_w.dst_old = old_w;
	end
	// Old destination as the design took it at the last edge
	always @(posedge I_CLK) old_q <= req_w.dst_old;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		$display("Checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	// One request, held valid so calls run back to back
	task automatic go(input logic c, input logic s32, input mvcu_cc_e cc, input mvcu_loc_e s,
		input mvcu_loc_e d, input logic [2:0] ix, input mvcu_flags_s f, input logic [31:0] v);
		req_r <= '{valid: 1'b1, is_cond: c, size32: s32, cc: cc, src: s, dst: d, dst_idx: ix,
			src_data: v, dst_old: '0};
		flags_r <= f;
		@(negedge I_CLK);
		chk("done", res_w.done, 1'b1);
	endtask : go
	// Own condition table: base test by code pair, odd codes invert it
	function automatic logic cc_true(input logic [3:0] cc, input mvcu_flags_s f);
		logic [7:0] b;
		b = {(f.sign_flag ^ f.overflow_flag) | f.zero_flag, f.sign_flag ^ f.overflow_flag,
			f.parity_flag, f.sign_flag, f.carry_flag | f.zero_flag, f.zero_flag, f.carry_flag,
			f.overflow_flag};
		return b[cc[3:1]] ^ cc[0];
	endfunction : cc_true
	initial begin
		logic e;
		repeat (10) @(negedge I_CLK);
		chk("cmov_rst", cmov_w, 1'b0);
		I_RST_N <= 1'b1;
		repeat (2) @(negedge I_CLK);
		chk("cmov", cmov_w, 1'b1);
		// Path table: legal paths write, forbidden ones are refused
		foreach (rows[k]) begin
			go(1'b0, 1'b1, MVCU_CC_O, rows[k].s, rows[k].d, 3'h0, 5'h00, 32'hC0DE_0000 + k);
			chk("illegal", res_w.illegal, rows[k].ill);
			chk("write_en", res_w.write_en, !rows[k].ill);
			chk("dst", res_w.dst, rows[k].d);
			if (!rows[k].ill) chk("data", res_w.data, 32'hC0DE_0000 + k);
		end
		// Every code against every flag pattern; true writes the new word, false keeps old
		for (int c = 0; c < 16; c++) begin
			for (int f = 0; f < 32; f++) begin
				e = cc_true(c[3:0], f[4:0]);
				go(1'b1, 1'b1, mvcu_cc_e'(c), MVCU_LOC_GPR, MVCU_LOC_GPR, 3'h7, f[4:0], 32'h8888_8888);
				chk("cond_true", res_w.cond_true, e);
				chk("cond_we", res_w.write_en, e);
				chk("cond_data", res_w.data, e ? 32'h8888_8888 : old_q);
			end
		end
		// Partial width keeps upper half; false keeps old; memory source allowed
		go(1'b1, 1'b0, MVCU_CC_E, MVCU_LOC_GPR, MVCU_LOC_GPR, 3'h6, 5'h04, 32'hABCD_1234);
		chk("half", res_w.data, 32'h6666_1234);
		chk("dst_idx", res_w.dst_idx, 3'h6);
		go(1'b1, 1'b1, MVCU_CC_E, MVCU_LOC_MEM, MVCU_LOC_GPR, 3'h5, 5'h00, 32'hDEAD_BEEF);
		chk("keep", res_w.data, 32'h5555_5555);
		chk("keep_we", res_w.write_en, 1'b0);
		go(1'b1, 1'b1, MVCU_CC_E, MVCU_LOC_MEM, MVCU_LOC_GPR, 3'h5, 5'h04, 32'hDEAD_BEEF);
		chk("mem_src", res_w.data, 32'hDEAD_BEEF);
		go(1'b1, 1'b1, MVCU_CC_E, MVCU_LOC_GPR, MVCU_LOC_MEM, 3'h5, 5'h04, 32'h0000_0000);
		chk("cond_dst", res_w.illegal, 1'b1);
		// Reset with a request still pending clears the result
		I_RST_N <= 1'b0;
		@(negedge I_CLK);
		chk("rst_done", res_w.done, 1'b0);
		chk("rst_we", res_w.write_en, 1'b0);
		chk("rst_cmov", cmov_w, 1'b0);
		I_RST_N <= 1'b1;
		req_r.valid <= 1'b0;
		repeat (2) @(negedge I_CLK);
		chk("cmov_again", cmov_w, 1'b1);
		summarize();
	end
	// Hang guard, well above the roughly 550 cycles the sequence needs
	always @(posedge I_CLK) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			summarize();
		end
	end
endmodule : move_and_conditional_move_unit_tb_top
